/* File: inc/pmoc_map.vh */
// constants of the clock generator control block: multiplier codes, defaults, field positions
// assumes inclusion by bare name from the design files
`ifndef PMOC_MAP_VH
`define PMOC_MAP_VH

// ----------------------------------------------------------------------
// multiplier codes
// ----------------------------------------------------------------------
`define PMOC_MUL_X3        3'h0
`define PMOC_MUL_X4        3'h1
`define PMOC_MUL_X5        3'h2
`define PMOC_MUL_X6        3'h3
`define PMOC_MUL_RSV4      3'h4
`define PMOC_MUL_X9_2      3'h5
`define PMOC_MUL_RSV6      3'h6
`define PMOC_MUL_X15_4     3'h7

// ----------------------------------------------------------------------
// ratio encoding: numerator and denominator fields of o_mul_ratio
// ----------------------------------------------------------------------
`define PMOC_NUM_MSB       7
`define PMOC_NUM_LSB       3
`define PMOC_DEN_MSB       2
`define PMOC_DEN_LSB       0
`define PMOC_RATIO_X3      8'h19
`define PMOC_RATIO_X4      8'h21
`define PMOC_RATIO_X5      8'h29
`define PMOC_RATIO_X6      8'h31
`define PMOC_RATIO_X9_2    8'h4A
`define PMOC_RATIO_X15_4   8'h7C
`define PMOC_RATIO_NONE    8'h00

// ----------------------------------------------------------------------
// power-up values
// ----------------------------------------------------------------------
`define PMOC_RST_MUL       3'h1
`define PMOC_RST_REF_FREQ_SELECT    1'h0
`define PMOC_RST_TEST      1'h0
`define PMOC_RST_OUT_ON    4'hF
`define PMOC_RST_ERR       1'h0
`define PMOC_RST_SLOT      2'h0
`define PMOC_RST_LINE      4'h0

`endif

/* File: src/pmoc_sync2.v */
// two flip-flop synchroniser for one level from outside the clock domain
// assumes i_clk free running; i_ce freezes it
`timescale 1ns/100ps

module pmoc_sync2 (
  input  wire i_clk,
  input  wire i_rstn,
  input  wire i_ce,
  input  wire i_d,
  output wire o_q
);

  reg meta_q;
  reg sync_q;

  // first stage is read only by the second stage
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else if (i_ce) begin
      meta_q <= i_d;
      sync_q <= meta_q;
    end
  end

  assign o_q = sync_q;

endmodule // pmoc_sync2

/* File: src/pmoc_ctrl.v */
// control of a four-output differential clock generator: multiplier decode, modes, output gating
// assumes settings come from a management-bus front end on i_clk as write strobes;
// pins and the reference/synthesized clocks are asynchronous and are synchronised here
//
// Behaviour
// - three-bit code picks multiplier 3,4,5,6,9/2,15/4; codes 100 and 110 reserved
// - after power-up the multiplier code selects factor 4 until software rewrites it
// - active-low bypass pin routes reference clock to outputs around the PLL
// - two static slot inputs are sampled to tell devices on one bus apart
// - four differential pairs, each pair driven or released on its own
// - output-enable pin low puts all four pairs in high impedance, overriding all
// - enabled, bypass asserted, test bit clear: reference pair drives all four outputs
// - at power-up test bit clears and all four per-output enable bits set
// - normal mode drives pairs whose enable bit is 1 with PLL clock, others released
`timescale 1ns/100ps
`include "pmoc_map.vh"

module pmoc_ctrl (
  input  wire       i_clk,
  input  wire       i_rstn,
  input  wire       i_ce,
  // settings write port
  input  wire       i_mul_wr,
  input  wire [2:0] i_mul_code,
  input  wire       i_ref_freq_select_wr,
  input  wire       i_ref_freq_select,
  input  wire       i_ctl_wr,
  input  wire       i_vendor_test_bit,
  input  wire [3:0] i_out_on_bits,
  // pins
  input  wire       i_out_enable,
  input  wire       i_bypass_n,
  input  wire       i_bus_slot_bit0,
  input  wire       i_bus_slot_bit1,
  input  wire       i_ref_in_pos,
  input  wire       i_ref_in_neg,
  input  wire       i_pll_pos,
  input  wire       i_pll_neg,
  // status
  output wire [2:0] o_mul_code,
  output wire [7:0] o_mul_ratio,
  output wire       o_ref_freq_select,
  output wire       o_vendor_test_bit,
  output wire [3:0] o_out_on_bits,
  output wire [1:0] o_bus_slot,
  output wire       o_bypass_active,
  output wire       o_test_mode,
  output wire       o_mul_reserved_err,
  // differential outputs, tri-state style: data plus enable per line
  output wire [3:0] o_out_pos,
  output wire [3:0] o_out_pos_oe,
  output wire [3:0] o_out_neg,
  output wire [3:0] o_out_neg_oe
);

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  // clock lines are sampled too, so outputs are a 100 MHz image of them;
  // fine for the bench, an analog mux would replace this in silicon
  wire [7:0] pin_raw = {i_pll_neg, i_pll_pos, i_ref_in_neg, i_ref_in_pos,
                        i_bus_slot_bit1, i_bus_slot_bit0, i_bypass_n, i_out_enable};
  wire [7:0] pin_s;

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_sync
      pmoc_sync2 u_sync (
        .i_clk  (i_clk),
        .i_rstn (i_rstn),
        .i_ce   (i_ce),
        .i_d    (pin_raw[gi]),
        .o_q    (pin_s[gi])
      );
    end
  endgenerate

  wire en_s     = pin_s[0];
  wire bypn_s   = pin_s[1];
  wire refp_s   = pin_s[4];
  wire refn_s   = pin_s[5];
  wire pllp_s   = pin_s[6];
  wire plln_s   = pin_s[7];

  // ----------------------------------------------------------------------
  // settings
  // ----------------------------------------------------------------------
  reg [2:0] mul_q;
  reg       ref_freq_select_q;
  reg       test_q;
  reg [3:0] on_q;
  reg       rsv_err_q;
  reg [1:0] slot_q;

  wire wr_rsv = i_mul_wr & ((i_mul_code == `PMOC_MUL_RSV4) |
                            (i_mul_code == `PMOC_MUL_RSV6));

  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      mul_q     <= `PMOC_RST_MUL;
      ref_freq_select_q  <= `PMOC_RST_REF_FREQ_SELECT;
      test_q    <= `PMOC_RST_TEST;
      on_q      <= `PMOC_RST_OUT_ON;
      rsv_err_q <= `PMOC_RST_ERR;
    end else if (i_ce) begin
      // reserved codes are refused so the PLL never sees an undefined ratio
      if (i_mul_wr && !wr_rsv) begin
        mul_q <= i_mul_code;
      end
      if (wr_rsv) begin
        rsv_err_q <= 1'b1;
      end else if (i_mul_wr) begin
        rsv_err_q <= 1'b0;
      end
      if (i_ref_freq_select_wr) begin
        ref_freq_select_q <= i_ref_freq_select;
      end
      if (i_ctl_wr) begin
        test_q <= i_vendor_test_bit;
        on_q   <= i_out_on_bits;
      end
    end
  end

  // straps are static, so tracking the synchronised level costs nothing;
  // a one-shot capture would only see the synchroniser's reset value
  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      slot_q <= `PMOC_RST_SLOT;
    end else if (i_ce) begin
      slot_q <= {pin_s[3], pin_s[2]};
    end
  end

  // ----------------------------------------------------------------------
  // multiplier decode
  // ----------------------------------------------------------------------
  reg [7:0] ratio;
  always @* begin
    case (mul_q)
      `PMOC_MUL_X3:    ratio = `PMOC_RATIO_X3;
      `PMOC_MUL_X4:    ratio = `PMOC_RATIO_X4;
      `PMOC_MUL_X5:    ratio = `PMOC_RATIO_X5;
      `PMOC_MUL_X6:    ratio = `PMOC_RATIO_X6;
      `PMOC_MUL_X9_2:  ratio = `PMOC_RATIO_X9_2;
      `PMOC_MUL_X15_4: ratio = `PMOC_RATIO_X15_4;
      default:         ratio = `PMOC_RATIO_NONE;
    endcase
  end

  // ----------------------------------------------------------------------
  // mode states, one-hot
  // ----------------------------------------------------------------------
  localparam [3:0] ST_OFF  = 4'h1;
  localparam [3:0] ST_TEST = 4'h2;
  localparam [3:0] ST_BYP  = 4'h4;
  localparam [3:0] ST_PLL  = 4'h8;

  reg [3:0] mode;
  always @* begin
    if (!en_s) begin
      mode = ST_OFF;
    end else if (test_q) begin
      mode = ST_TEST;
    end else if (!bypn_s) begin
      mode = ST_BYP;
    end else begin
      mode = ST_PLL;
    end
  end

  // ----------------------------------------------------------------------
  // output registers
  // ----------------------------------------------------------------------
  reg [3:0] pos_q;
  reg [3:0] neg_q;
  reg [3:0] pos_oe_q;
  reg [3:0] neg_oe_q;
  reg [3:0] pos_d;
  reg [3:0] neg_d;
  reg [3:0] oe_d;

  always @* begin
    case (mode)
      ST_OFF: begin
        pos_d = 4'h0;
        neg_d = 4'h0;
        oe_d  = 4'h0;
      end
      ST_BYP: begin
        pos_d = {4{refp_s}};
        neg_d = {4{refn_s}};
        oe_d  = 4'hF;
      end
      ST_PLL: begin
        pos_d = {4{pllp_s}} & on_q;
        neg_d = {4{plln_s}} & on_q;
        oe_d  = on_q;
      end
      // vendor test is undefined; outputs are released as the safe choice
      default: begin
        pos_d = 4'h0;
        neg_d = 4'h0;
        oe_d  = 4'h0;
      end
    endcase
  end

  always @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pos_q    <= `PMOC_RST_LINE;
      neg_q    <= `PMOC_RST_LINE;
      pos_oe_q <= `PMOC_RST_LINE;
      neg_oe_q <= `PMOC_RST_LINE;
    end else if (i_ce) begin
      pos_q    <= pos_d;
      neg_q    <= neg_d;
      pos_oe_q <= oe_d;
      neg_oe_q <= oe_d;
    end
  end

  assign o_out_pos          = pos_q;
  assign o_out_neg          = neg_q;
  assign o_out_pos_oe       = pos_oe_q;
  assign o_out_neg_oe       = neg_oe_q;
  assign o_mul_code         = mul_q;
  assign o_mul_ratio        = ratio;
  assign o_ref_freq_select  = ref_freq_select_q;
  assign o_vendor_test_bit  = test_q;
  assign o_out_on_bits      = on_q;
  assign o_bus_slot         = slot_q;
  assign o_bypass_active    = (mode == ST_BYP);
  assign o_test_mode        = (mode == ST_TEST);
  assign o_mul_reserved_err = rsv_err_q;

endmodule // pmoc_ctrl

/* File: bench/pmoc_ctrl_checker.sv */
// checker for pmoc_ctrl: output gating by mode and multiplier write handling
// assumes i_ce held high; sees only the block's ports
`timescale 1ns/100ps
module pmoc_ctrl_checker (
  input logic       i_clk,
  input logic       i_rstn,
  input logic       i_mul_wr,
  input logic [2:0] i_mul_code,
  input logic       i_out_enable,
  input logic       i_ref_in_pos,
  input logic [2:0] o_mul_code,
  input logic [3:0] o_out_on_bits,
  input logic       o_bypass_active,
  input logic       o_test_mode,
  input logic       o_mul_reserved_err,
  input logic [3:0] o_out_pos,
  input logic [3:0] o_out_neg,
  input logic [3:0] o_out_pos_oe,
  input logic [3:0] o_out_neg_oe
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  // codes 100 and 110 share bit2 set and bit0 clear
  wire rsv = i_mul_wr && i_mul_code[2] && !i_mul_code[0];
  wire pll_or_off = !o_bypass_active && !o_test_mode;
  property p_pair; o_out_pos_oe == o_out_neg_oe; endproperty
  a_pair: assert property (p_pair) else $error("pair enables differ");
  property p_off; !i_out_enable [*4] |-> o_out_pos_oe == 4'h0 && !o_bypass_active; endproperty
  a_off: assert property (p_off) else $error("driven while disabled");
  property p_test; $past(o_test_mode) |-> o_out_pos_oe == 4'h0; endproperty
  a_test: assert property (p_test) else $error("driven in test mode");
  property p_byp; $past(o_bypass_active) |-> o_out_pos_oe == 4'hF; endproperty
  a_byp: assert property (p_byp) else $error("bypass not on all outputs");
  // data lags the pin by two sync stages plus the output register
  property p_bdat; $past(o_bypass_active) |-> o_out_pos == {4{$past(i_ref_in_pos, 3)}}; endproperty
  a_bdat: assert property (p_bdat) else $error("bypass data wrong");
  property p_pll; $past(pll_or_off) && o_out_pos_oe != 4'h0
    && $stable(o_out_on_bits) |-> o_out_pos_oe == o_out_on_bits; endproperty
  a_pll: assert property (p_pll) else $error("enables differ from on bits");
  // both reference and loop pairs are complementary, and released lines carry 0
  property p_cmp; o_out_neg == (~o_out_pos & o_out_pos_oe); endproperty
  a_cmp: assert property (p_cmp) else $error("complement line wrong");
  property p_res; rsv |=> o_mul_reserved_err && $stable(o_mul_code); endproperty
  a_res: assert property (p_res) else $error("reserved code taken");
  property p_ok; i_mul_wr && !rsv |=> o_mul_code == $past(i_mul_code) && !o_mul_reserved_err;
  endproperty
  a_ok: assert property (p_ok) else $error("valid code not stored");
endmodule // pmoc_ctrl_checker

bind pmoc_ctrl pmoc_ctrl_checker pmoc_ctrl_checker_inst (.i_clk, .i_rstn, .i_mul_wr, .i_mul_code,
  .i_out_enable, .i_ref_in_pos, .o_mul_code, .o_out_on_bits, .o_bypass_active, .o_test_mode,
  .o_mul_reserved_err, .o_out_pos, .o_out_neg, .o_out_pos_oe, .o_out_neg_oe);

/* File: bench/pmoc_clk_src.sv */
// reference and synthesized clock pairs standing in for oscillator and analog loop
// assumes nothing; both run free, as a board oscillator does
`timescale 1ns/100ps
module pmoc_clk_src (
  output logic o_ref_pos,
  output logic o_ref_neg,
  output logic o_pll_pos,
  output logic o_pll_neg
);
  // pll period unrelated to the sampling clock so edges drift across it
  // pll edges sit off the whole-ns grid so none meets a sampling edge in one step
  initial begin
    o_ref_pos = 1'b0;
    o_pll_pos = 1'b0;
    #0.3;
    forever #23 o_pll_pos = ~o_pll_pos;
  end
  always #80 o_ref_pos = ~o_ref_pos;
  assign o_ref_neg = ~o_ref_pos;
  assign o_pll_neg = ~o_pll_pos;
endmodule // pmoc_clk_src

/* File: bench/pll_multiplier_output_control_test.sv */
// self-checking bench for pmoc_ctrl: power-up values, multiplier writes, output modes
// assumes the bound checker and pmoc_clk_src; i_ce held high
`timescale 1ns/100ps
module pll_multiplier_output_control_test;
  logic        i_clk = 1'b0, i_rstn = 1'b0, i_ce = 1'b1, i_mul_wr = 1'b0, i_ctl_wr = 1'b0;
  logic        i_ref_freq_select_wr = 1'b0, i_ref_freq_select = 1'b0, i_vendor_test_bit = 1'b0;
  logic        i_out_enable = 1'b1, i_bypass_n = 1'b1, i_bus_slot_bit0 = 1'b1;
  logic        i_bus_slot_bit1 = 1'b0, wr_pend = 1'b0, probe = 1'b0, en, bp, t;
  logic [2:0]  i_mul_code = 3'h0, cur = 3'h1;
  logic [3:0]  i_out_on_bits = 4'hF, oe;
  logic        ref_pos, ref_neg, pll_pos, pll_neg;
  wire  [2:0]  o_mul_code;
  wire  [7:0]  o_mul_ratio;
  wire  [3:0]  o_out_on_bits, o_out_pos, o_out_pos_oe, o_out_neg, o_out_neg_oe;
  wire  [1:0]  o_bus_slot;
  wire         o_ref_freq_select, o_vendor_test_bit, o_bypass_active, o_test_mode;
  wire         o_mul_reserved_err;
  logic [7:0]  rt [8] = '{8'h19, 8'h21, 8'h29, 8'h31, 8'h00, 8'h4A, 8'h00, 8'h7C};
  logic [23:0] qw[$], qm[$];
  logic [31:0] r;
  integer      seed = 32'h8093, fail_count = 0, comparisons = 0;

  pmoc_ctrl pmoc_ctrl_inst (.i_clk, .i_rstn, .i_ce, .i_mul_wr, .i_mul_code, .i_ref_freq_select_wr,
    .i_ref_freq_select, .i_ctl_wr, .i_vendor_test_bit, .i_out_on_bits, .i_out_enable, .i_bypass_n,
    .i_bus_slot_bit0, .i_bus_slot_bit1, .i_ref_in_pos(ref_pos), .i_ref_in_neg(ref_neg),
    .i_pll_pos(pll_pos), .i_pll_neg(pll_neg), .o_mul_code, .o_mul_ratio, .o_ref_freq_select,
    .o_vendor_test_bit, .o_out_on_bits, .o_bus_slot, .o_bypass_active, .o_test_mode,
    .o_mul_reserved_err, .o_out_pos, .o_out_pos_oe, .o_out_neg, .o_out_neg_oe);
  pmoc_clk_src pmoc_clk_src_inst (.o_ref_pos(ref_pos), .o_ref_neg(ref_neg), .o_pll_pos(pll_pos),
    .o_pll_neg(pll_neg));

  always #5 i_clk = ~i_clk;

  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask

  task give_verdict;
    $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // strobe stays high across calls, so writes go back to back
  task wmul(input logic [2:0] c);
    @(posedge i_clk);
    i_mul_wr <= 1'b1;
    i_mul_code <= c;
    if (c[2] && !c[0])
      qw.push_back({12'h0, 1'b1, cur, rt[cur]});
    else begin
      cur = c;
      qw.push_back({12'h0, 1'b0, c, rt[c]});
    end
  endtask

  // ----------------------------------------------------------------------
  // monitor: results land one edge after the strobe that caused them
  // ----------------------------------------------------------------------
  always @(posedge i_clk) wr_pend <= i_mul_wr;
  always @(negedge i_clk) begin
    if (wr_pend && qw.size() > 0)
      chk({12'h0, o_mul_reserved_err, o_mul_code, o_mul_ratio}, qw.pop_front());
    if (probe && qm.size() > 0)
      chk({14'h0, o_out_pos_oe, o_out_neg_oe, o_bypass_active, o_test_mode}, qm.pop_front());
  end

  initial begin
    repeat (12) @(posedge i_clk);
    i_rstn <= 1'b1;
    @(negedge i_clk);
    chk({6'h0, o_mul_code, o_mul_ratio, o_ref_freq_select, o_vendor_test_bit, o_out_on_bits,
      o_mul_reserved_err}, {6'h0, 3'h1, 8'h21, 2'h0, 4'hF, 1'h0});
    for (int c = 0; c < 8; c++)
      wmul(c[2:0]);
    repeat (10) begin
      r = $random(seed);
      wmul(r[2:0]);
    end
    @(posedge i_clk);
    i_mul_wr <= 1'b0;
    i_ref_freq_select_wr <= 1'b1;
    i_ref_freq_select <= 1'b1;
    @(posedge i_clk);
    i_ref_freq_select_wr <= 1'b0;
    @(negedge i_clk);
    chk({23'h0, o_ref_freq_select}, 24'h1);
    chk({22'h0, o_bus_slot}, 24'h1);
    // pins settle through two sync stages, so probe well after the change
    repeat (24) begin
      r = $random(seed);
      en = r[0] | r[1];
      bp = r[2];
      t = r[3] & r[4];
      oe = !en ? 4'h0 : t ? 4'h0 : !bp ? 4'hF : r[8:5];
      @(posedge i_clk);
      i_out_enable <= en;
      i_bypass_n <= bp;
      i_ctl_wr <= 1'b1;
      i_vendor_test_bit <= t;
      i_out_on_bits <= r[8:5];
      @(posedge i_clk);
      i_ctl_wr <= 1'b0;
      repeat (4) @(posedge i_clk);
      probe <= 1'b1;
      qm.push_back({14'h0, oe, oe, en & !t & !bp, en & t});
      @(posedge i_clk);
      probe <= 1'b0;
    end
    give_verdict;
  end

  // about ten times the expected run length
  initial begin
    #20000;
    fail_count++;
    give_verdict;
  end
endmodule // pll_multiplier_output_control_test
